/* src/spc_ctrl.sv */
// Serial port control register, rate generator, flag gating and pin steering.
module spc_ctrl
	import spc_pkg::*;
#(
	parameter int RATE_W = spc_pkg::RATE_W_DEF
) (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Wishbone slave
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [spc_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [spc_pkg::SEL_W-1:0]  sel_i,
	input  wire logic [spc_pkg::DATA_W-1:0] dat_i,
	output logic      [spc_pkg::DATA_W-1:0] dat_o,
	output logic                           ack_o,
	// Shifter side
	input  wire logic                      tx_empty_i,
	input  wire logic                      rx_not_empty_i,
	input  wire logic                      tx_underrun_i,
	input  wire logic                      collision_i,
	input  wire logic                      rx_overrun_i,
	input  wire logic                      shift_out_i,
	input  wire logic                      sck_phase_i,
	input  wire logic                      ss_value_i,
	output logic                           tx_empty_flag_o,
	output logic                           rx_not_empty_flag_o,
	output logic                           rate_tick_o,
	output logic                           phase_o,
	output logic                           shift_in_o,
	output logic                           irq_o,
	// Serial pins
	input  wire logic                      sck_i,
	input  wire logic                      ss_n_i,
	input  wire logic                      mosi_i,
	input  wire logic                      miso_i,
	output logic                           sck_o,
	output logic                           sck_oe_n_o,
	output logic                           ss_o,
	output logic                           ss_oe_n_o,
	output logic                           mosi_o,
	output logic                           mosi_oe_n_o,
	output logic                           miso_o,
	output logic                           miso_oe_n_o
);
	import spc_pkg::*;

	if (RATE_W < 9 || RATE_W > 16) begin : g_chk
		$error("RATE_W must lie between 9 and 16");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]        ctrl_ff, nxt_ctrl;
	logic [RATE_W-1:0] reload_ff, nxt_reload;
	logic [RATE_W-1:0] cnt_ff, nxt_cnt;
	logic              abort_ff, nxt_abort;
	logic              tmo_ff, nxt_tmo;
	logic              sck_prev_ff, nxt_sck_prev;
	logic              ack_ff, nxt_ack;
	logic [31:0]       dat_ff, nxt_dat;
	logic              txe_ff, nxt_txe, rxne_ff, nxt_rxne, tick_ff, nxt_tick;
	logic              irq_ff, nxt_irq, phs_ff, nxt_phs, sin_ff, nxt_sin;
	logic [7:0]        pin_ff, nxt_pin;

	spc_mode_t mode;
	logic      master, rgc, gen_sck, gen_tmr, gen_wd, restart, expire;
	logic      tx_ok, rx_ok, req, wr, hit_ctrl, hit_rate, hit_stat;
	logic      sck_val, data_val;
	logic [6:0]  stat;
	logic [31:0] rdata;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		unique case ({ctrl_ff[C_ENHI], ctrl_ff[C_ENLO]})
			2'b00: mode = SPC_OFF;
			2'b01: mode = SPC_RX;
			2'b10: mode = SPC_TX;
			2'b11: mode = SPC_TRX;
		endcase
	end

	assign master  = ctrl_ff[C_MSEL];
	assign rgc     = ctrl_ff[C_RGC];
	assign tx_ok   = mode == SPC_TX || mode == SPC_TRX;
	assign rx_ok   = mode == SPC_RX || mode == SPC_TRX;
	assign gen_sck = mode != SPC_OFF && master;
	assign gen_tmr = mode == SPC_OFF && rgc;
	assign gen_wd  = mode != SPC_OFF && !master && rgc;
	// A clock edge or an idle select restarts the watchdog, so only a stall
	// inside a frame can time out.
	assign restart = gen_wd && (sck_i != sck_prev_ff || ss_n_i);
	assign expire  = (gen_sck || gen_tmr || gen_wd) && !restart
		&& cnt_ff == RATE_W'(1);

	assign req      = cyc_i && stb_i;
	assign wr       = req && we_i && ack_ff;
	assign hit_ctrl = adr_i == ADDR_W'({CTRL_IDX, 2'b00});
	assign hit_rate = adr_i == ADDR_W'({RATE_IDX, 2'b00});
	assign hit_stat = adr_i == ADDR_W'({STAT_IDX, 2'b00});
	assign stat     = {tmo_ff, rx_overrun_i, abort_ff, collision_i,
		tx_underrun_i, rxne_ff, txe_ff};

	// Reading the counter whole avoids mismatched halves while it runs.
	always_comb begin
		rdata = 32'h0000_0000;
		if (hit_ctrl) begin
			rdata[7:0] = ctrl_ff;
		end else if (hit_rate) begin
			rdata[RATE_W-1:0] = rgc ? cnt_ff : reload_ff;
		end else if (hit_stat) begin
			rdata[6:0] = stat;
		end
	end

	// ----------------------------------------------------------------
	// Registers, bus and generator
	// ----------------------------------------------------------------
	always_comb begin
		nxt_ctrl     = ctrl_ff;
		nxt_reload   = reload_ff;
		nxt_ack      = req && !ack_ff;
		nxt_dat      = (req && !ack_ff) ? rdata : dat_ff;
		nxt_sck_prev = sck_i;
		nxt_abort    = abort_ff;
		nxt_tmo      = tmo_ff;
		if (wr && hit_ctrl && sel_i[0]) begin
			nxt_ctrl = dat_i[7:0];
		end
		if (wr && hit_rate) begin
			if (sel_i[0]) begin
				nxt_reload[7:0] = dat_i[7:0];
			end
			if (sel_i[1]) begin
				nxt_reload[RATE_W-1:8] = dat_i[RATE_W-1:8];
			end
		end
		if (wr && hit_stat && sel_i[0]) begin
			nxt_abort = abort_ff && !dat_i[S_ABRT];
			nxt_tmo = tmo_ff && !dat_i[S_TMO];
		end
		// Set wins over a clear in the same cycle.
		if (expire && gen_wd) begin
			nxt_abort = 1'b1;
		end
		if (expire && gen_tmr) begin
			nxt_tmo = 1'b1;
		end
		// A stopped generator holds the reload, so it restarts a full period.
		if (!(gen_sck || gen_tmr || gen_wd) || restart || expire) begin
			nxt_cnt = reload_ff;
		end else begin
			nxt_cnt = cnt_ff - RATE_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff     <= CTRL_RST;
			reload_ff   <= '0;
			cnt_ff      <= '0;
			abort_ff    <= 1'b0;
			tmo_ff      <= 1'b0;
			sck_prev_ff <= 1'b0;
			ack_ff      <= 1'b0;
			dat_ff      <= 32'h0000_0000;
		end else begin
			ctrl_ff     <= nxt_ctrl;
			reload_ff   <= nxt_reload;
			cnt_ff      <= nxt_cnt;
			abort_ff    <= nxt_abort;
			tmo_ff      <= nxt_tmo;
			sck_prev_ff <= nxt_sck_prev;
			ack_ff      <= nxt_ack;
			dat_ff      <= nxt_dat;
		end
	end

	// ----------------------------------------------------------------
	// Flags, request and pins
	// ----------------------------------------------------------------
	assign sck_val  = sck_phase_i ^ ctrl_ff[C_CPOL];
	assign data_val = tx_ok ? shift_out_i : 1'b1;

	always_comb begin
		nxt_txe  = tx_empty_i && tx_ok;
		nxt_rxne = rx_not_empty_i && rx_ok;
		nxt_tick = expire && gen_sck;
		nxt_phs  = ctrl_ff[C_PHS];
		nxt_sin  = master ? miso_i : mosi_i;
		nxt_irq  = tx_underrun_i || collision_i || rx_overrun_i || abort_ff
			|| tmo_ff
			|| (ctrl_ff[C_DIRQ] && (nxt_txe || nxt_rxne));
		// Pin order: sck, ss, mosi, miso; value then active-low enable.
		nxt_pin = {sck_val, 1'b1, ss_value_i, 1'b1, data_val, 1'b1, data_val, 1'b1};
		if (mode != SPC_OFF && master) begin
			nxt_pin[6] = 1'b0;
			nxt_pin[4] = 1'b0;
			nxt_pin[2] = 1'b0;
		end else if (mode != SPC_OFF) begin
			nxt_pin[0] = 1'b0;
		end
		// Open drain only pulls low; a high level is left to the pull-up.
		if (ctrl_ff[C_OD]) begin
			nxt_pin[6] = nxt_pin[6] || sck_val;
			nxt_pin[4] = nxt_pin[4] || ss_value_i;
			nxt_pin[2] = nxt_pin[2] || data_val;
			nxt_pin[0] = nxt_pin[0] || data_val;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txe_ff  <= 1'b0;
			rxne_ff <= 1'b0;
			tick_ff <= 1'b0;
			phs_ff  <= 1'b0;
			sin_ff  <= 1'b0;
			irq_ff  <= 1'b0;
			pin_ff  <= 8'h55;
		end else begin
			txe_ff  <= nxt_txe;
			rxne_ff <= nxt_rxne;
			tick_ff <= nxt_tick;
			phs_ff  <= nxt_phs;
			sin_ff  <= nxt_sin;
			irq_ff  <= nxt_irq;
			pin_ff  <= nxt_pin;
		end
	end

	assign dat_o               = dat_ff;
	assign ack_o               = ack_ff;
	assign tx_empty_flag_o     = txe_ff;
	assign rx_not_empty_flag_o = rxne_ff;
	assign rate_tick_o         = tick_ff;
	assign phase_o             = phs_ff;
	assign shift_in_o          = sin_ff;
	assign irq_o               = irq_ff;
	assign {sck_o, sck_oe_n_o, ss_o, ss_oe_n_o} = pin_ff[7:4];
	assign {mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o} = pin_ff[3:0];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence rd_rate_s;
		req && !ack_ff && !we_i && hit_rate;
	endsequence

	data_gate_a: assert property (!ctrl_ff[C_DIRQ] && !tx_underrun_i && !collision_i
		&& !rx_overrun_i && !abort_ff && !tmo_ff |=> !irq_o)
		else $error("data flag raised request while gated");
	error_irq_a: assert property ((tx_underrun_i || collision_i || rx_overrun_i)
		|=> irq_o) else $error("error flag did not raise request");
	data_irq_a: assert property (ctrl_ff[C_DIRQ] && tx_ok && tx_empty_i
		|=> irq_o && tx_empty_flag_o) else $error("enabled data flag gave no request");
	off_pins_a: assert property (mode == SPC_OFF |=> sck_oe_n_o && mosi_oe_n_o
		&& miso_oe_n_o && ss_oe_n_o) else $error("disabled port drives a pin");
	rx_only_a: assert property (mode == SPC_RX |=> !tx_empty_flag_o
		&& mosi_o && miso_o) else $error("receive only sent data or flagged");
	tx_only_a: assert property (mode == SPC_TX |=> !rx_not_empty_flag_o)
		else $error("transmit only flagged receive");
	trx_flag_a: assert property (mode == SPC_TRX && rx_not_empty_i
		|=> rx_not_empty_flag_o) else $error("receive flag lost in duplex");
	rate_read_a: assert property (rd_rate_s ##0 (rgc == 1'b0)
		|=> ack_o && dat_o[RATE_W-1:0] == $past(reload_ff))
		else $error("reload not returned on read");
	cnt_read_a: assert property (rd_rate_s ##0 rgc
		|=> ack_o && dat_o[RATE_W-1:0] == $past(cnt_ff))
		else $error("counter not returned on read");
	timer_out_a: assert property (gen_tmr && cnt_ff == RATE_W'(1)
		|=> tmo_ff ##1 irq_o) else $error("timer time-out missed");
	slave_stop_a: assert property (mode != SPC_OFF && !master && !rgc
		|=> cnt_ff == $past(reload_ff) && !rate_tick_o)
		else $error("slave generator running");
	master_tick_a: assert property (gen_sck && cnt_ff == RATE_W'(1)
		|=> rate_tick_o) else $error("master clock tick missing");
	wd_abort_a: assert property (gen_wd && !restart && cnt_ff == RATE_W'(1)
		|=> abort_ff ##1 irq_o) else $error("watchdog abort missing");
	clk_pol_a: assert property (gen_sck && !ctrl_ff[C_OD]
		|=> sck_o == ($past(sck_phase_i) ^ $past(ctrl_ff[C_CPOL])) && !sck_oe_n_o)
		else $error("clock polarity wrong");
	open_drain_a: assert property (ctrl_ff[C_OD] && gen_sck
		|=> mosi_oe_n_o == mosi_o) else $error("open drain drove high");
	slave_dir_a: assert property (mode != SPC_OFF && !master && !ctrl_ff[C_OD]
		|=> sck_oe_n_o && mosi_oe_n_o && !miso_oe_n_o) else $error("slave direction wrong");
endmodule

/* src/spc_pkg.sv */
// Shared constants and types for the serial port control block.
package spc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 14;
	localparam int          DATA_W     = 32;
	localparam int          SEL_W      = 4;
	localparam logic [11:0] CTRL_IDX   = 12'hF62;
	localparam logic [11:0] RATE_IDX   = 12'hF64;
	localparam logic [11:0] STAT_IDX   = 12'hF65;
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam int          RATE_W_DEF = 16;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	localparam int C_DIRQ = 7;
	localparam int C_ENHI = 6;
	localparam int C_RGC  = 5;
	localparam int C_PHS  = 4;
	localparam int C_CPOL = 3;
	localparam int C_OD   = 2;
	localparam int C_MSEL = 1;
	localparam int C_ENLO = 0;

	// ----------------------------------------------------------------
	// Status fields
	// ----------------------------------------------------------------
	localparam int S_TXE  = 0;
	localparam int S_RXNE = 1;
	localparam int S_UND  = 2;
	localparam int S_COL  = 3;
	localparam int S_ABRT = 4;
	localparam int S_OVR  = 5;
	localparam int S_TMO  = 6;

	typedef enum logic [1:0] {SPC_OFF, SPC_RX, SPC_TX, SPC_TRX} spc_mode_t;
endpackage

/* bench/spc_far_end.sv */
// External serial device model that faces the serial pins of the control block.
module spc_far_end (
	// Clock and frame control
	input  wire logic clk_i,
	input  wire logic frame_i,
	input  wire logic stall_i,
	// Serial pins
	output logic      sck_o,
	output logic      ss_n_o,
	output logic      mosi_o,
	output logic      miso_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] div_ff = 3'h0;
	logic [7:0] pat_ff = 8'hA5;
	initial begin
		sck_o = 1'h0;
		ss_n_o = 1'h1;
		mosi_o = 1'h0;
		miso_o = 1'h1;
	end
	always @(posedge clk_i) begin
		div_ff <= div_ff + 3'h1;
		pat_ff <= {pat_ff[6:0], pat_ff[7] ^ pat_ff[5]};
		ss_n_o <= !frame_i;
		// The clock stands still outside frames and while stalled, as a real master's does.
		if (!frame_i)
			sck_o <= 1'h0;
		else if (!stall_i && div_ff == 3'h3)
			sck_o <= !sck_o;
		// Unselected lines keep changing so that a stale level never passes for data.
		mosi_o <= frame_i ? pat_ff[7] : !mosi_o;
		miso_o <= pat_ff[0];
	end
endmodule

/* bench/serial_port_control_register_tb.sv */
// Self-checking bench for the serial port control block.
module serial_port_control_register_tb import spc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, ack_o;
	logic [ADDR_W-1:0] adr_i = '0;
	logic [SEL_W-1:0]  sel_i = 4'hF;
	logic [DATA_W-1:0] dat_i = '0, dat_o, q, p;
	logic tx_empty_i, rx_not_empty_i, tx_underrun_i, collision_i, rx_overrun_i;
	logic shift_out_i, sck_phase_i, ss_value_i, tx_empty_flag_o, rx_not_empty_flag_o;
	logic rate_tick_o, phase_o, shift_in_o, irq_o, sck_i, ss_n_i, mosi_i, miso_i;
	logic sck_o, sck_oe_n_o, ss_o, ss_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
	logic frame = 1'h0, stall = 1'h0, p_sck, p_ss_n, p_mosi, p_miso;
	logic [7:0]  stim = 8'h0, ctl = 8'h0;
	logic [1:0]  pin_q;
	logic [15:0] rel;
	logic [11:0] got;
	logic [31:0] seed = 32'hF229;
	int errors = 0, tests_run = 0, n;
	always #12.5 clk_i = !clk_i;
	assign {ss_value_i, tx_empty_i, rx_not_empty_i, tx_underrun_i, collision_i, rx_overrun_i,
		shift_out_i, sck_phase_i} = stim;
	assign sck_i = (sck_oe_n_o !== 1'h0) ? p_sck : sck_o;
	assign ss_n_i = (ss_oe_n_o !== 1'h0) ? p_ss_n : ss_o;
	assign mosi_i = (mosi_oe_n_o !== 1'h0) ? p_mosi : mosi_o;
	assign miso_i = (miso_oe_n_o !== 1'h0) ? p_miso : miso_o;
	assign got = {tx_empty_flag_o, rx_not_empty_flag_o, irq_o, phase_o, shift_in_o,
		(ctl[C_ENHI] | ctl[C_ENLO]) ? {sck_oe_n_o, ss_oe_n_o, mosi_oe_n_o, miso_oe_n_o,
		ctl[C_MSEL] ? mosi_o : miso_o, ctl[C_MSEL] & sck_o, ctl[C_MSEL] & ss_o} : 7'h0};
	always @(posedge clk_i) pin_q <= {miso_i, mosi_i};

	spc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.tx_empty_i(tx_empty_i), .rx_not_empty_i(rx_not_empty_i), .tx_underrun_i(tx_underrun_i),
		.collision_i(collision_i), .rx_overrun_i(rx_overrun_i), .shift_out_i(shift_out_i),
		.sck_phase_i(sck_phase_i), .ss_value_i(ss_value_i), .tx_empty_flag_o(tx_empty_flag_o),
		.rx_not_empty_flag_o(rx_not_empty_flag_o), .rate_tick_o(rate_tick_o),
		.phase_o(phase_o), .shift_in_o(shift_in_o), .irq_o(irq_o), .sck_i(sck_i),
		.ss_n_i(ss_n_i), .mosi_i(mosi_i), .miso_i(miso_i), .sck_o(sck_o),
		.sck_oe_n_o(sck_oe_n_o), .ss_o(ss_o), .ss_oe_n_o(ss_oe_n_o), .mosi_o(mosi_o),
		.mosi_oe_n_o(mosi_oe_n_o), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o));
	spc_far_end far (.clk_i(clk_i), .frame_i(frame), .stall_i(stall), .sck_o(p_sck),
		.ss_n_o(p_ss_n), .mosi_o(p_mosi), .miso_o(p_miso));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [11:0] expect_v(input logic [7:0] c, input logic [7:0] s,
		input logic si);
		logic tf, rf;
		tf = s[6] & c[C_ENHI];
		rf = s[5] & c[C_ENLO];
		return {tf, rf, (|s[4:2]) | (c[C_DIRQ] & (tf | rf)), c[C_PHS], si,
			(c[C_ENHI] | c[C_ENLO]) ? {!c[C_MSEL], !c[C_MSEL], !c[C_MSEL], c[C_MSEL],
			c[C_ENHI] ? s[1] : 1'h1, c[C_MSEL] & (s[0] ^ c[C_CPOL]), c[C_MSEL] & s[7]} : 7'h0};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= {idx, 2'h0};
		dat_i <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'h1 && k < 40);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
		if (k >= 40) chk(32'h0, 32'h1);
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic rate_read(input logic [7:0] c, input logic live);
		wb(1'h1, CTRL_IDX, {24'h0, c});
		settle(4);
		wb(1'h0, RATE_IDX, 32'h0);
		p = q;
		wb(1'h0, RATE_IDX, 32'h0);
		if (live)
			chk({30'h0, p[15:0] >= 16'h1 && p[15:0] <= rel, p[15:0] != q[15:0]}, 32'h3);
		else
			chk({p[15:0], q[15:0]}, {rel, rel});
	endtask
	task automatic stat(input logic [2:0] e);
		wb(1'h0, STAT_IDX, 32'h0);
		chk({29'h0, irq_o, q[S_ABRT], q[S_TMO]}, {29'h0, e});
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h0, CTRL_IDX, 32'h0);
		chk(q, 32'h0);
		wb(1'h0, 12'h100, 32'h0);
		chk(q, 32'h0);
		for (int i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			ctl = seed[15:8];
			ctl[C_RGC] = 1'h0;
			ctl[C_OD] = 1'h0;
			{ctl[C_DIRQ], ctl[C_ENHI], ctl[C_ENLO]} = i[2:0];
			if (!ctl[C_ENHI] && ctl[C_ENLO]) ctl[C_MSEL] = 1'h0;
			@(posedge clk_i);
			stim <= {seed[7], i[3], i[4], seed[2:0] & {3{seed[3] & seed[4]}}, seed[5], seed[6]};
			wb(1'h1, CTRL_IDX, {24'h0, ctl});
			settle(3);
			chk(got, expect_v(ctl, stim, ctl[C_MSEL] ? pin_q[1] : pin_q[0]));
			wb(1'h0, CTRL_IDX, 32'h0);
			chk(q, {24'h0, ctl});
		end
		seed = lfsr(seed);
		rel = {12'h001, seed[3:0]};
		@(posedge clk_i);
		stim <= 8'h0;
		wb(1'h1, RATE_IDX, {16'h0, rel});
		rate_read(8'h00, 1'h0);
		repeat (3 * rel) @(posedge clk_i);
		stat(3'h0);
		rate_read(8'h20, 1'h1);
		repeat (rel + 4) @(posedge clk_i);
		stat(3'h5);
		rate_read(8'h43, 1'h0);
		n = 0;
		repeat (4 * rel) begin
			@(negedge clk_i);
			if (rate_tick_o === 1'h1) n++;
		end
		chk(n, 32'h4);
		rate_read(8'h63, 1'h1);
		wb(1'h1, CTRL_IDX, 32'h47);
		for (int b = 0; b < 2; b++) begin
			@(posedge clk_i);
			stim <= {b[0], 5'h0, b[0], 1'h0};
			settle(3);
			chk({ss_oe_n_o, mosi_oe_n_o, sck_oe_n_o}, {b[0], b[0], 1'h0});
		end
		@(posedge clk_i);
		frame <= 1'h1;
		stall <= 1'h1;
		wb(1'h1, CTRL_IDX, 32'h41);
		wb(1'h1, STAT_IDX, 32'h50);
		repeat (3 * rel) @(posedge clk_i);
		stat(3'h0);
		@(posedge clk_i);
		stall <= 1'h0;
		wb(1'h1, CTRL_IDX, 32'h61);
		repeat (3 * rel) @(posedge clk_i);
		stat(3'h0);
		@(posedge clk_i);
		stall <= 1'h1;
		repeat (rel + 6) @(posedge clk_i);
		stat(3'h6);
		sel_i <= 4'hE;
		wb(1'h1, CTRL_IDX, 32'h0);
		sel_i <= 4'hF;
		wb(1'h0, CTRL_IDX, 32'h0);
		chk(q, 32'h61);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		complete_run();
	end
endmodule
